// ### sdram_init_seq.sv
// Purpose: device-side power-up and reinitialization sequencer
// Assumes: controller keeps its own timing waits; cke_i and commands are synchronous
// Notes: auto-init time is counted from the reset command
`timescale 1ns/100ps
`default_nettype none
module sdram_init_seq (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // link from controller (pins)
    input wire logic cke_i,
    input wire logic [2:0] cmd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] op_i,
    // read data back
    output logic [7:0] dq_o,
    output logic dq_oe_o,
    // status
    output logic idle_o,
    output logic banks_open_o
);
    logic cke_s1_q, cke_q;
    logic [2:0] cmd_s1_q, cmd_q;
    logic [7:0] addr_s1_q, addr_q, op_s1_q, op_q;
    init_pkg::seq_state_type state_q, state_d;
    logic [init_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] info_q, info_d, dq_q, dq_d;
    logic oe_q, oe_d, idle_q, idle_d, open_q, open_d;
    logic is_reset, is_zq, is_read;

    // two-stage synchronisers for the pins
    always_ff @(posedge clk_i) begin
        cke_s1_q <= cke_i;
        cke_q <= cke_s1_q;
        cmd_s1_q <= cmd_i;
        cmd_q <= cmd_s1_q;
        addr_s1_q <= addr_i;
        addr_q <= addr_s1_q;
        op_s1_q <= op_i;
        op_q <= op_s1_q;
    end

    // decode; commands only count with clock-enable high
    assign is_reset = cke_q && cmd_q == init_pkg::MODE_REGISTER_WRITE_CMD
        && addr_q == init_pkg::RESET_ADDR;
    assign is_zq = cke_q && cmd_q == init_pkg::MODE_REGISTER_WRITE_CMD
        && addr_q == init_pkg::IO_CAL_ADDR && op_q == init_pkg::ZQ_INIT_CODE;
    assign is_read = cke_q && cmd_q == init_pkg::MODE_REGISTER_READ_CMD;

    // next-state logic of the sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        info_d = info_q;
        open_d = open_q;
        dq_d = init_pkg::MR_ZERO;
        oe_d = 1'b0;
        unique case (state_q)
            init_pkg::ST_POWERED_OFF: begin
                if (cke_q) begin
                    state_d = init_pkg::ST_WAIT_RESET;
                end
            end
            init_pkg::ST_WAIT_RESET: begin
                info_d[init_pkg::AUTO_INIT_BIT] = 1'b1;
            end
            init_pkg::ST_AUTO_INIT: begin
                // counts down to completion; bound keeps us under the max time
                if (cnt_q == '0) begin
                    info_d[init_pkg::AUTO_INIT_BIT] = 1'b0;
                    state_d = init_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            init_pkg::ST_IDLE: begin
                if (is_zq) begin
                    state_d = init_pkg::ST_ZQ_CAL;
                    cnt_d = init_pkg::CNT_W'(init_pkg::ZQ_CAL_CYCLES - 1);
                end
                if (cke_q && cmd_q == init_pkg::CMD_ACT) begin
                    open_d = 1'b1;
                end
                if (cke_q && cmd_q == init_pkg::CMD_PREA) begin
                    open_d = 1'b0;
                end
            end
            init_pkg::ST_ZQ_CAL: begin
                if (cnt_q == '0) begin
                    info_d[init_pkg::ZQ_INFO_LO +: 2] = init_pkg::ZQ_SELF_TEST_OK;
                    state_d = init_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
        // a reset write restarts auto-init, skipping the wait-reset step, in any powered state
        if (is_reset && state_q != init_pkg::ST_POWERED_OFF) begin
            state_d = init_pkg::ST_AUTO_INIT;
            cnt_d = init_pkg::CNT_W'(init_pkg::AUTO_INIT_CYCLES / 2);
            info_d = init_pkg::MR_ZERO;
            info_d[init_pkg::AUTO_INIT_BIT] = 1'b1;
            open_d = 1'b0;
        end
        // read back the info register; others read zero
        if (is_read) begin
            oe_d = 1'b1;
            dq_d = (addr_q == init_pkg::DEVICE_INFO_ADDR) ? info_d : init_pkg::MR_ZERO;
        end
        idle_d = (state_d == init_pkg::ST_IDLE) && !open_d;
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= init_pkg::ST_POWERED_OFF;
            cnt_q <= '0;
            info_q <= init_pkg::MR_ZERO;
            dq_q <= init_pkg::MR_ZERO;
            oe_q <= 1'b0;
            idle_q <= 1'b0;
            open_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            info_q <= info_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            idle_q <= idle_d;
            open_q <= open_d;
        end
    end

    // outputs come straight from registers, so no glitch reaches a pin
    assign dq_o = dq_q;
    assign dq_oe_o = oe_q;
    assign idle_o = idle_q;
    assign banks_open_o = open_q;

    // cycles spent in auto-init, watched against the time limit
    logic [init_pkg::CNT_W-1:0] busy_cnt_q, busy_cnt_d;
    always_comb begin
        busy_cnt_d = '0;
        if (state_q == init_pkg::ST_AUTO_INIT) begin
            busy_cnt_d = busy_cnt_q + 1'b1;
        end
    end
    // register only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // bound in cycles for the auto-init checks
    localparam int AUTO_MAX = init_pkg::AUTO_INIT_CYCLES;

    sequence reset_cmd_s;
        is_reset && state_q != init_pkg::ST_POWERED_OFF;
    endsequence
    sequence reach_idle_s;
        ##[1:AUTO_MAX] state_q == init_pkg::ST_IDLE;
    endsequence

    auto_init_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
        reset_cmd_s ##1 (!is_reset) [*8] |-> reach_idle_s)
        else $error("auto init not done in time");
    hiz_cke_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !cke_q |=> !oe_q)
        else $error("driving while cke low");
    status_bit_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == init_pkg::ST_AUTO_INIT |-> info_q[init_pkg::AUTO_INIT_BIT])
        else $error("status bit clear during init");
    idle_precharged_a: assert property (@(posedge clk_i) disable iff (reset_i)
        idle_q |-> !open_q)
        else $error("idle with open bank");
    zq_update_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == init_pkg::ST_ZQ_CAL && cnt_q == '0 && !is_reset |=>
        info_q[init_pkg::ZQ_INFO_LO +: 2] == init_pkg::ZQ_SELF_TEST_OK)
        else $error("calibration status not updated");
    reinit_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
        reset_cmd_s |=> state_q == init_pkg::ST_AUTO_INIT && info_q[init_pkg::AUTO_INIT_BIT])
        else $error("reset did not restart init");
    idle_accept_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(state_q == init_pkg::ST_IDLE) && !open_q && !is_reset |-> ##[0:1] idle_q)
        else $error("idle flag missing");
    read_answer_a: assert property (@(posedge clk_i) disable iff (reset_i)
        is_read |=> oe_q)
        else $error("read not answered");

    // info reads report busy during the countdown, ready once idle
    sequence info_read_s;
        is_read && addr_q == init_pkg::DEVICE_INFO_ADDR;
    endsequence
    busy_report_a: assert property (@(posedge clk_i) disable iff (reset_i)
        info_read_s ##0 (state_q == init_pkg::ST_AUTO_INIT && cnt_q != '0)
        |=> dq_q[init_pkg::AUTO_INIT_BIT])
        else $error("busy read shows complete");
    ready_report_a: assert property (@(posedge clk_i) disable iff (reset_i)
        info_read_s ##0 (state_q == init_pkg::ST_IDLE) |=> !dq_q[init_pkg::AUTO_INIT_BIT])
        else $error("ready read shows busy");
    init_time_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == init_pkg::ST_AUTO_INIT
        |-> busy_cnt_q < init_pkg::CNT_W'(init_pkg::AUTO_INIT_CYCLES))
        else $error("auto init over time limit");
    quiet_output_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !is_read |=> !oe_q && dq_q == init_pkg::MR_ZERO)
        else $error("output without a read");
endmodule
`default_nettype wire

// ### init_pkg.sv
// Purpose: shared constants for the memory power-up sequencing block
// Assumes: 40 MHz core clock, 25 ns period
// Notes: time figures kept in their own units, cycle counts derived
package init_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int AUTO_INIT_MAX_TIME_US = 10;
    localparam int AUTO_INIT_CYCLES = (AUTO_INIT_MAX_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int ZQ_CAL_TIME_US = 1;
    localparam int ZQ_CAL_CYCLES = (ZQ_CAL_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;
    // command encoding on cmd_i
    localparam logic [2:0] NO_OPERATION_CMD = 3'h0;
    localparam logic [2:0] MODE_REGISTER_WRITE_CMD = 3'h1;
    localparam logic [2:0] MODE_REGISTER_READ_CMD = 3'h2;
    localparam logic [2:0] CMD_PREA = 3'h3;
    localparam logic [2:0] CMD_ACT = 3'h4;
    // mode register addresses and the ZQ init code
    localparam logic [7:0] DEVICE_INFO_ADDR = 8'h00;
    localparam logic [7:0] IO_CAL_ADDR = 8'h0A;
    localparam logic [7:0] RESET_ADDR = 8'h3F;
    localparam logic [7:0] ZQ_INIT_CODE = 8'hFF;
    // device info field positions and values
    localparam int AUTO_INIT_BIT = 0;
    localparam int ZQ_INFO_LO = 3;
    localparam logic [1:0] ZQ_SELF_TEST_OK = 2'h3;
    localparam logic [7:0] MR_ZERO = 8'h00;
    typedef enum logic [2:0] {
        ST_POWERED_OFF, ST_WAIT_RESET, ST_AUTO_INIT, ST_IDLE, ST_ZQ_CAL
    } seq_state_type;
endpackage

// ### ctrl_model.sv
// Purpose: memory controller model driving the sequencer pins
// Assumes: 25 ns clock, inside the boot clock range
// Notes: spare address and data lines toggle so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
    // clock
    input wire logic clk_i,
    // pins to the device
    output var logic cke_o,
    output var logic [2:0] cmd_o,
    output var logic [7:0] addr_o,
    output var logic [7:0] op_o
);
    // waits rounded up to whole cycles
    localparam int CKE_LOW_CYC = 5;
    localparam int NOP_CYC = 8000;
    localparam int RST_CYC = 40;
    // clock-enable low from time zero
    initial begin
        cke_o = 1'b0;
        cmd_o = init_pkg::NO_OPERATION_CMD;
        addr_o = 8'h00;
        op_o = 8'h00;
    end
    // one command for one cycle, then a no-op
    task automatic issue(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cmd_o <= c;
        addr_o <= a;
        op_o <= d;
        @(posedge clk_i);
        cmd_o <= init_pkg::NO_OPERATION_CMD;
        addr_o <= ~a;
        op_o <= ~d;
    endtask
    task automatic idle_cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // low hold with clock running, then the long no-op phase
    task automatic power_up();
        idle_cycles(CKE_LOW_CYC);
        cke_o <= 1'b1;
        idle_cycles(NOP_CYC);
    endtask
    // precharge-all on every call, reset write, no-op wait; also reinit
    task automatic reset_cmd();
        issue(init_pkg::CMD_PREA, 8'h00, 8'h00);
        issue(init_pkg::MODE_REGISTER_WRITE_CMD, init_pkg::RESET_ADDR, 8'h00);
        idle_cycles(RST_CYC);
    endtask
    task automatic power_off();
        @(posedge clk_i);
        cke_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### sdram_power_up_init_sequence_tb_top.sv
// Purpose: self-checking bench for the power-up sequencer
// Assumes: ctrl_model keeps every controller-side wait
// Notes: the full no-op phase runs, about 9000 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module sdram_power_up_init_sequence_tb_top;
    logic clk_i;
    logic reset_i = 1'b1;
    logic cke;
    logic [2:0] cmd;
    logic [7:0] addr;
    logic [7:0] op;
    logic [7:0] dq_o;
    logic dq_oe_o;
    logic idle_o;
    logic banks_open_o;
    logic [7:0] rd;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    ctrl_model ctrl (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .addr_o(addr), .op_o(op));
    sdram_init_seq DUT (.clk_i(clk_i), .reset_i(reset_i), .cke_i(cke), .cmd_i(cmd),
        .addr_i(addr), .op_i(op), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .idle_o(idle_o),
        .banks_open_o(banks_open_o));
    // 40 MHz clock, inside the boot range for reads
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, about twice the expected run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    // read a register, answer must stand exactly one cycle
    task automatic read_mode_reg(input logic [7:0] a);
        int n;
        n = 0;
        ctrl.issue(init_pkg::MODE_REGISTER_READ_CMD, a, 8'h00);
        #1;
        while (dq_oe_o !== 1'b1 && n < 6) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHECK(dq_oe_o, 1'b1)
        rd = dq_o;
        @(posedge clk_i);
        #1;
        `CHECK({dq_oe_o, dq_o}, 9'h000)
    endtask
    // busy bit set first, then clear within the 10 us limit; 70 polls of 5 cycles fit
    task automatic poll_ready();
        int n;
        n = 0;
        read_mode_reg(init_pkg::DEVICE_INFO_ADDR);
        `CHECK(rd[0], 1'b1)
        while (rd[0] !== 1'b0 && n < 70) begin
            read_mode_reg(init_pkg::DEVICE_INFO_ADDR);
            n++;
        end
        `CHECK(rd[0], 1'b0)
        `CHECK(idle_o, 1'b1)
    endtask
    // reads are ignored while clock-enable is low
    task automatic t_quiet();
        ctrl.issue(init_pkg::MODE_REGISTER_READ_CMD, init_pkg::DEVICE_INFO_ADDR, 8'h00);
        repeat (5) begin
            @(posedge clk_i);
            #1;
            `CHECK(dq_oe_o, 1'b0)
        end
    endtask
    task automatic t_zq_config();
        ctrl.issue(init_pkg::MODE_REGISTER_WRITE_CMD, init_pkg::IO_CAL_ADDR,
            init_pkg::ZQ_INIT_CODE);
        ctrl.idle_cycles(45);
        read_mode_reg(init_pkg::DEVICE_INFO_ADDR);
        `CHECK(rd[4:3], init_pkg::ZQ_SELF_TEST_OK)
        // registers other than the info register answer zero
        read_mode_reg(init_pkg::IO_CAL_ADDR);
        `CHECK(rd, init_pkg::MR_ZERO)
        for (int i = 1; i < 4; i++) begin
            ctrl.issue(init_pkg::MODE_REGISTER_WRITE_CMD, 8'(i), 8'h00);
        end
        #1;
        `CHECK(idle_o, 1'b1)
    endtask
    task automatic t_banks();
        ctrl.issue(init_pkg::CMD_ACT, 8'h00, 8'h00);
        ctrl.idle_cycles(4);
        #1;
        `CHECK({banks_open_o, idle_o}, 2'h2)
        ctrl.issue(init_pkg::CMD_PREA, 8'h00, 8'h00);
        ctrl.idle_cycles(4);
        #1;
        `CHECK({banks_open_o, idle_o}, 2'h1)
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHECK({dq_oe_o, idle_o, banks_open_o}, 3'h0)
        t_quiet();
        ctrl.power_up();
        ctrl.reset_cmd();
        poll_ready();
        t_zq_config();
        t_banks();
        ctrl.issue(init_pkg::CMD_ACT, 8'h00, 8'h00);
        ctrl.reset_cmd();
        #1;
        `CHECK(idle_o, 1'b0)
        poll_ready();
        ctrl.power_off();
        ctrl.idle_cycles(3);
        t_quiet();
        end_sim();
    end
endmodule
`default_nettype wire
